// [hw/fas_regs.svh]
`ifndef FAS_REGS_SVH
`define FAS_REGS_SVH
// register offsets on the internal register port
`define FAS_CFG_ADDR 8'h02
`define FAS_PIN_DEF_ADDR 8'h04
`define FAS_PIN_STAT_ADDR 8'h06
`define FAS_ALM_EN_ADDR 8'h08
`define FAS_ALM_STAT_ADDR 8'h0A
`define FAS_TACH_BASE_ADDR 8'h0C
// reset values; all pins come up released (output high)
`define FAS_CFG_RST 8'h00
`define FAS_PIN_DEF_RST 8'hFF
`define FAS_ALM_EN_RST 5'h00
// alarm bit positions in enable and status
`define FAS_ALM_MIN 0
`define FAS_ALM_MAX 1
`define FAS_ALM_OVF 2
`define FAS_ALM_FULL 3
`define FAS_ALM_SYNC 4
`define FAS_ALM_W 5
// two-bit fields of the pin definition register
`define FAS_PD_ALERT_LSB 0
`define FAS_PD_FULL_LSB 2
`define FAS_PD_SYNC_LSB 4
// configuration fields
`define FAS_CFG_MODE_LSB 4
`define FAS_CFG_PRE_W 3
// codes that flag loss of regulation or overflow
`define FAS_DAC_MIN 8'h00
`define FAS_DAC_MAX 8'hFF
`define FAS_TACH_SAT 8'hFF
// internal oscillator, as a rate, and its half period in core cycles
`define FAS_CORE_HZ 100000000
`define FAS_OSC_HZ 254000
`define FAS_OSC_HALF (`FAS_CORE_HZ / (2 * `FAS_OSC_HZ))
`endif

// [hw/fas_pkg.sv]
package fas_pkg;
  // two-bit pin definition field; FAS_PD_ALT is the pin's special use
  typedef enum logic [1:0] {
    FAS_PD_CLK_IN = 2'h0,
    FAS_PD_ALT = 2'h1,
    FAS_PD_LOW = 2'h2,
    FAS_PD_HIGH = 2'h3
  } fas_pin_def_t;
  // loop mode field of the configuration register
  typedef enum logic [1:0] {
    FAS_LOOP_CLOSED = 2'h2
  } fas_loop_t;
endpackage

// [hw/fas_alarm_latch.sv]
`timescale 1ns/1ps
module fas_alarm_latch #(
  parameter int N = 5
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // raw conditions, enables and the status read strobe
  input wire logic [N-1:0] cond_i,
  input wire logic [N-1:0] en_i,
  input wire logic rd_clr_i,
  // latched status and combined alarm level
  output logic [N-1:0] status_o,
  output logic alert_o
);
  logic [N-1:0] status;
  logic [N-1:0] next_status;

  // a present condition beats the read clear; a disabled bit drops at once
  always_comb begin
    next_status = en_i & (cond_i | (status & ~{N{rd_clr_i}}));
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign status_o = status;
  assign alert_o = |(status & en_i);

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_hold_latched:
  assert property (!rd_clr_i |=>
                   (($past(status) & $past(en_i)) & ~status) == '0)
    else $error("latched alarm dropped without a status read");

  a_read_release:
  assert property (rd_clr_i |=> status == ($past(en_i) & $past(cond_i)))
    else $error("status read did not keep exactly the live alarms");

  a_disable_clear:
  assert property (nrst_i |=> (status & ~$past(en_i)) == '0)
    else $error("disabled alarm still latched");
endmodule

// [hw/fas_sync_clk.sv]
`timescale 1ns/1ps
`include "fas_regs.svh"
module fas_sync_clk #(
  parameter int unsigned HALF = `FAS_OSC_HALF
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // pin definition field for the sync pin
  input wire fas_pkg::fas_pin_def_t pin_def_i,
  // sync clock pin, open drain
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe_n_o,
  // one-cycle time base tick for the loop
  output logic tick_o
);
  localparam logic [15:0] HALF16 = 16'(HALF);
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic osc;
  logic next_osc;
  logic pin_q;
  logic oe_n;
  logic next_oe_n;
  logic tick;
  logic next_tick;

  // internal oscillator always runs so a switch to master is glitch free
  always_comb begin
    next_div_cnt = div_cnt + 16'h0001;
    next_osc = osc;
    if (div_cnt >= HALF16 - 16'h0001) begin
      next_div_cnt = 16'h0000;
      next_osc = ~osc;
    end
    next_tick = 1'b0;
    next_oe_n = 1'b1;
    case (pin_def_i)
      fas_pkg::FAS_PD_ALT: begin
        next_oe_n = next_osc;
        next_tick = next_osc & ~osc;
      end
      fas_pkg::FAS_PD_CLK_IN: begin
        next_tick = sync_clock_pin_i & ~pin_q;
      end
      fas_pkg::FAS_PD_LOW: next_oe_n = 1'b0;
      default: next_oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 16'h0000;
      osc <= 1'b0;
      pin_q <= 1'b1;
      oe_n <= 1'b1;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      osc <= next_osc;
      pin_q <= sync_clock_pin_i;
      oe_n <= next_oe_n;
      tick <= next_tick;
    end
  end

  // open drain: only ever pulls low
  assign sync_clock_pin_o = 1'b0;
  assign sync_clock_pin_oe_n_o = oe_n;
  assign tick_o = tick;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_clk_master_out:
  assert property ($past(pin_def_i) == fas_pkg::FAS_PD_ALT |->
                   sync_clock_pin_oe_n_o == osc && tick_o == $rose(osc))
    else $error("sync pin does not follow the internal clock");

  a_clk_slave_in:
  assert property (pin_def_i == fas_pkg::FAS_PD_CLK_IN |=>
                   sync_clock_pin_oe_n_o &&
                   tick_o == ($past(sync_clock_pin_i) && !$past(pin_q)))
    else $error("sync pin input mode does not take the received clock");
endmodule

// [hw/fas_alarm_top.sv]
`timescale 1ns/1ps
`include "fas_regs.svh"
module fas_alarm_top #(
  parameter int N_TACH = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register port from the serial front end
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // regulation loop and tachometer inputs
  input wire logic [7:0] dac_code_i,
  input wire logic [N_TACH-1:0] tach_pulse_i,
  input wire logic count_start_i,
  // alert capable pin, open drain
  input wire logic alert_capable_pin_i,
  output logic alert_capable_pin_o,
  output logic alert_capable_pin_oe_n_o,
  // full-on pin, open drain
  input wire logic full_on_pin_i,
  output logic full_on_pin_o,
  output logic full_on_pin_oe_n_o,
  // sync clock pin, open drain
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe_n_o,
  // controls toward the regulation loop
  output logic closed_loop_o,
  output logic [`FAS_CFG_PRE_W-1:0] prescale_o,
  output logic full_on_req_o,
  output logic time_tick_o,
  output logic alarm_active_o
);

  // picks one two-bit field out of the pin definition register
  function automatic fas_pkg::fas_pin_def_t pd_field(
    input logic [7:0] r,
    input int lsb
  );
    pd_field = fas_pkg::fas_pin_def_t'(r[lsb +: 2]);
  endfunction

  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [7:0] pin_def;
  logic [7:0] next_pin_def;
  logic [`FAS_ALM_W-1:0] alm_en;
  logic [`FAS_ALM_W-1:0] next_alm_en;
  logic [`FAS_ALM_W-1:0] alm_status;
  logic [`FAS_ALM_W-1:0] alm_cond;
  logic alarm_any;
  logic stat_rd;
  logic [7:0] reg_rdata;
  logic [7:0] next_rdata;
  logic [7:0] tach_cnt [N_TACH];
  logic [7:0] next_tach_cnt [N_TACH];
  logic tach_ovf;
  logic alert_oe_n;
  logic next_alert_oe_n;
  logic full_oe_n;
  logic next_full_oe_n;
  logic full_req;
  logic next_full_req;
  fas_pkg::fas_pin_def_t alert_mode;
  fas_pkg::fas_pin_def_t full_mode;
  fas_pkg::fas_pin_def_t sync_mode;

  assign alert_mode = pd_field(pin_def, `FAS_PD_ALERT_LSB);
  assign full_mode = pd_field(pin_def, `FAS_PD_FULL_LSB);
  assign sync_mode = pd_field(pin_def, `FAS_PD_SYNC_LSB);
  assign stat_rd = reg_rd_i && (reg_addr_i == `FAS_ALM_STAT_ADDR);

  // register writes; reserved enable bits are not stored and read zero
  always_comb begin
    next_cfg = cfg;
    next_pin_def = pin_def;
    next_alm_en = alm_en;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `FAS_CFG_ADDR: next_cfg = reg_wdata_i;
        `FAS_PIN_DEF_ADDR: next_pin_def = reg_wdata_i;
        `FAS_ALM_EN_ADDR: begin
          next_alm_en = reg_wdata_i[`FAS_ALM_W-1:0];
        end
        default: next_alm_en = alm_en;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= `FAS_CFG_RST;
      pin_def <= `FAS_PIN_DEF_RST;
      alm_en <= `FAS_ALM_EN_RST;
    end else begin
      cfg <= next_cfg;
      pin_def <= next_pin_def;
      alm_en <= next_alm_en;
    end
  end

  // tach counters count pulses per window and stick at full scale
  always_comb begin
    tach_ovf = 1'b0;
    for (int i = 0; i < N_TACH; i++) begin
      next_tach_cnt[i] = tach_cnt[i];
      if (count_start_i) begin
        next_tach_cnt[i] = 8'h00;
      end else if (tach_pulse_i[i] && tach_cnt[i] != `FAS_TACH_SAT) begin
        next_tach_cnt[i] = tach_cnt[i] + 8'h01;
      end
      if (tach_cnt[i] == `FAS_TACH_SAT) begin
        tach_ovf = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < N_TACH; i++) begin
        tach_cnt[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < N_TACH; i++) begin
        tach_cnt[i] <= next_tach_cnt[i];
      end
    end
  end

  // raw alarm conditions; pin levels count whatever the pin is set up as
  always_comb begin
    alm_cond = '0;
    alm_cond[`FAS_ALM_MIN] = (dac_code_i == `FAS_DAC_MIN);
    alm_cond[`FAS_ALM_MAX] = (dac_code_i == `FAS_DAC_MAX);
    alm_cond[`FAS_ALM_OVF] = tach_ovf;
    alm_cond[`FAS_ALM_FULL] = !full_on_pin_i;
    alm_cond[`FAS_ALM_SYNC] = !sync_clock_pin_i;
  end

  // sticky status, gated by the enables, cleared by read or disable
  fas_alarm_latch #(
    .N(`FAS_ALM_W)
  ) u_latch (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .cond_i(alm_cond),
    .en_i(alm_en),
    .rd_clr_i(stat_rd),
    .status_o(alm_status),
    .alert_o(alarm_any)
  );

  // read data is registered and holds between reads
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `FAS_CFG_ADDR: next_rdata = cfg;
      `FAS_PIN_DEF_ADDR: next_rdata = pin_def;
      `FAS_PIN_STAT_ADDR: begin
        next_rdata = {5'h00, sync_clock_pin_i, full_on_pin_i,
                      alert_capable_pin_i};
      end
      `FAS_ALM_EN_ADDR: next_rdata = {3'h0, alm_en};
      `FAS_ALM_STAT_ADDR: next_rdata = {3'h0, alm_status};
      default: begin
        for (int i = 0; i < N_TACH; i++) begin
          if (reg_addr_i == `FAS_TACH_BASE_ADDR + 8'(i)) begin
            next_rdata = tach_cnt[i];
          end
        end
      end
    endcase
    if (!reg_rd_i) begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // pin drivers; registered so a field change cannot glitch the pin
  always_comb begin
    case (alert_mode)
      fas_pkg::FAS_PD_ALT: next_alert_oe_n = ~alarm_any;
      fas_pkg::FAS_PD_LOW: next_alert_oe_n = 1'b0;
      default: next_alert_oe_n = 1'b1;
    endcase
    next_full_oe_n = (full_mode != fas_pkg::FAS_PD_LOW);
    next_full_req = (full_mode == fas_pkg::FAS_PD_ALT) && !full_on_pin_i;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alert_oe_n <= 1'b1;
      full_oe_n <= 1'b1;
      full_req <= 1'b0;
    end else begin
      alert_oe_n <= next_alert_oe_n;
      full_oe_n <= next_full_oe_n;
      full_req <= next_full_req;
    end
  end

  // clock master or slave on the sync pin
  fas_sync_clk #(
    .HALF(`FAS_OSC_HALF)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pin_def_i(sync_mode),
    .sync_clock_pin_i(sync_clock_pin_i),
    .sync_clock_pin_o(sync_clock_pin_o),
    .sync_clock_pin_oe_n_o(sync_clock_pin_oe_n_o),
    .tick_o(time_tick_o)
  );

  // outputs; open drain pins only ever pull low
  assign reg_rdata_o = reg_rdata;
  assign alert_capable_pin_o = 1'b0;
  assign alert_capable_pin_oe_n_o = alert_oe_n;
  assign full_on_pin_o = 1'b0;
  assign full_on_pin_oe_n_o = full_oe_n;
  assign full_on_req_o = full_req;
  assign alarm_active_o = alarm_any;
  assign closed_loop_o = (cfg[`FAS_CFG_MODE_LSB +: 2] ==
                          fas_pkg::FAS_LOOP_CLOSED);
  assign prescale_o = cfg[`FAS_CFG_PRE_W-1:0];

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_min_alarm:
  assert property (alm_en[`FAS_ALM_MIN] && dac_code_i == 8'h00 |=>
                   alm_status[`FAS_ALM_MIN] || !alm_en[`FAS_ALM_MIN])
    else $error("minimum-output alarm not latched");

  a_max_alarm:
  assert property (alm_en[`FAS_ALM_MAX] && dac_code_i == 8'hFF |=>
                   alm_status[`FAS_ALM_MAX] || !alm_en[`FAS_ALM_MAX])
    else $error("maximum-output alarm not latched");

  a_ovf_alarm:
  assert property (alm_en[`FAS_ALM_OVF] && tach_cnt[0] == 8'hFF |=>
                   alm_status[`FAS_ALM_OVF] || !alm_en[`FAS_ALM_OVF])
    else $error("overflow alarm not latched");

  a_pin_low:
  assert property (alm_en[`FAS_ALM_SYNC] && !sync_clock_pin_i |=>
                   alm_status[`FAS_ALM_SYNC] || !alm_en[`FAS_ALM_SYNC])
    else $error("sync pin low alarm not latched");

  a_enable_gate:
  assert property (!alm_en[`FAS_ALM_MIN] ##1 !alm_en[`FAS_ALM_MIN] |->
                   !alm_status[`FAS_ALM_MIN])
    else $error("minimum-output alarm latched while disabled");

  a_alert_chain:
  assert property ((alm_en[`FAS_ALM_MAX] && dac_code_i == 8'hFF) ##1
                   (alm_en[`FAS_ALM_MAX] && alert_mode == fas_pkg::FAS_PD_ALT)
                   |=> !alert_capable_pin_oe_n_o)
    else $error("alert pin not pulled two cycles after an alarm");

  a_alert_release:
  assert property (alm_en == '0 ##1 alm_en == '0 |=>
                   alert_capable_pin_oe_n_o ||
                   $past(alert_mode) == fas_pkg::FAS_PD_LOW)
    else $error("alert still active with every alarm disabled");

  a_tach_sat:
  assert property (tach_cnt[0] == 8'hFF && !count_start_i |=>
                   tach_cnt[0] == 8'hFF)
    else $error("tach counter wrapped past full scale");

  a_closed_loop:
  assert property (closed_loop_o == (cfg[5:4] == 2'b10))
    else $error("closed loop select does not match mode field");

  a_stat_read:
  assert property (stat_rd |=> reg_rdata_o == {3'h0, $past(alm_status)})
    else $error("status read returned the wrong value");
endmodule

// [tb/fas_host_model.sv]
`timescale 1ns/1ps
module fas_host_model (
  // clock
  input wire logic core_clk_i,
  // register port toward the block
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  // alert wire as the host interrupt input sees it
  input wire logic alert_n_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one write; address and data are scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // one read; data is taken after the edge that carries it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
  // status read that answers an alert
  task automatic service(output logic [7:0] d);
    rd(8'h0A, d);
  endtask
  // linked parts must share loop mode and prescaler
  task automatic closed_loop(input logic [2:0] pre);
    wr(8'h02, {2'h0, 2'h2, 1'b0, pre});
  endtask
endmodule

// [tb/test_fas_alarm_top.sv]
`timescale 1ns/1ps
`include "fas_regs.svh"
module test_fas_alarm_top;
  logic core_clk_i;
  logic nrst_i;
  logic [7:0] addr, wdata, rdata, dac, d;
  logic wr, rd, cstart, full_ext, sync_ext;
  logic [3:0] tach;
  logic alert_oe_n, full_oe_n, sync_oe_n, closed_loop, full_req, tick, act;
  logic [2:0] pre;
  int bad_count, comparisons, ticks, n;
  // open-drain wires with pull-ups: low when anyone enables its driver
  wire logic alert_lvl = alert_oe_n ? 1'b1 : 1'b0;
  wire logic full_lvl = full_oe_n ? full_ext : 1'b0;
  wire logic sync_lvl = sync_oe_n ? sync_ext : 1'b0;

  fas_alarm_top #(.N_TACH(4)) i_dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .dac_code_i(dac), .tach_pulse_i(tach), .count_start_i(cstart),
    .alert_capable_pin_i(alert_lvl), .alert_capable_pin_o(),
    .alert_capable_pin_oe_n_o(alert_oe_n),
    .full_on_pin_i(full_lvl), .full_on_pin_o(),
    .full_on_pin_oe_n_o(full_oe_n),
    .sync_clock_pin_i(sync_lvl), .sync_clock_pin_o(),
    .sync_clock_pin_oe_n_o(sync_oe_n),
    .closed_loop_o(closed_loop), .prescale_o(pre),
    .full_on_req_o(full_req), .time_tick_o(tick), .alarm_active_o(act)
  );
  fas_host_model i_host (
    .core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .alert_n_i(alert_lvl)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // tick pulses counted for the time base checks
  always @(posedge core_clk_i) begin
    if (tick === 1'b1) ticks <= ticks + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      @(negedge core_clk_i) tach = 4'h5;
      @(negedge core_clk_i) tach = 4'h0;
    end
  endtask

  task automatic t_reset;
    check({5'h00, alert_oe_n, full_oe_n, sync_oe_n}, 8'h07);
    i_host.rd(8'h08, d);
    check(d, 8'h00);
    i_host.rd(8'h0A, d);
    check(d, 8'h00);
    i_host.rd(8'h30, d); // unmapped place reads zero
    check(d, 8'h00);
    i_host.wr(8'h08, 8'hFF);
    i_host.rd(8'h08, d);
    check(d, 8'h1F);
    i_host.wr(8'h08, 8'h00);
  endtask

  task automatic t_minmax;
    i_host.wr(8'h04, 8'hFD);
    i_host.wr(8'h08, 8'h03);
    for (int k = 0; k < 2; k++) begin
      dac = k ? 8'hFF : 8'h00;
      cyc(3);
      check({7'h00, alert_lvl}, 8'h00);
      dac = 8'h80;
      cyc(4);
      check({7'h00, alert_lvl}, 8'h00);
      i_host.service(d);
      check(d, 8'h01 << k);
      cyc(2);
      check({7'h00, alert_lvl}, 8'h01);
    end
    // cause still present at the read keeps the alert
    dac = 8'h00;
    cyc(3);
    i_host.service(d);
    cyc(3);
    check({7'h00, alert_lvl}, 8'h00);
    i_host.wr(8'h08, 8'h02);
    cyc(3);
    check({6'h00, act, alert_lvl}, 8'h01);
    // alert pin released when it is not in alert use
    i_host.wr(8'h04, 8'hFF);
    i_host.wr(8'h08, 8'h03);
    cyc(3);
    check({6'h00, act, alert_lvl}, 8'h03);
    i_host.wr(8'h04, 8'hFD);
    cyc(3);
    check({7'h00, alert_lvl}, 8'h00);
    dac = 8'h80;
    i_host.wr(8'h08, 8'h00);
  endtask

  task automatic t_ovf;
    i_host.wr(8'h08, 8'h04);
    @(negedge core_clk_i) cstart = 1'b1;
    @(negedge core_clk_i) cstart = 1'b0;
    pulses(254);
    cyc(3);
    check({7'h00, act}, 8'h00);
    pulses(1);
    cyc(3);
    check({7'h00, act}, 8'h01);
    pulses(3);
    i_host.rd(8'h0E, d);
    check(d, 8'hFF);
    i_host.rd(8'h0C, d);
    check(d, 8'hFF);
    i_host.service(d);
    check(d, 8'h04);
    @(negedge core_clk_i) cstart = 1'b1;
    @(negedge core_clk_i) cstart = 1'b0;
    i_host.service(d);
    cyc(3);
    check({7'h00, alert_lvl}, 8'h01);
    i_host.wr(8'h08, 8'h00);
  endtask

  task automatic t_pins;
    i_host.wr(8'h08, 8'h18);
    for (int m = 0; m < 4; m++) begin
      i_host.wr(8'h04, {4'hF, m[1:0], 2'h1});
      full_ext = 1'b0;
      cyc(3);
      // full-on request only in special use, pulled low only in low use
      check({6'h00, full_req, full_oe_n}, {6'h00, m == 1, m != 2});
      i_host.service(d);
      check(d & 8'h08, 8'h08);
      full_ext = 1'b1;
    end
    i_host.wr(8'h04, 8'hFD);
    i_host.service(d);
    i_host.service(d);
    sync_ext = 1'b0;
    cyc(3);
    i_host.service(d);
    check(d, 8'h10);
    sync_ext = 1'b1;
    i_host.service(d);
    i_host.wr(8'h08, 8'h00);
  endtask

  task automatic t_sync;
    i_host.closed_loop(3'h3);
    check({4'h0, closed_loop, pre}, 8'h0B);
    i_host.wr(8'h04, 8'hDD);
    n = 0;
    while (sync_oe_n !== 1'b0 && n < 500) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (sync_oe_n === 1'b0 && n < 500) begin
      cyc(1);
      n++;
    end
    check(8'(n), 8'(`FAS_OSC_HALF));
    ticks = 0;
    cyc(5);
    check(8'(ticks), 8'h01);
    // slave: the block follows a clock fed on the pin
    i_host.wr(8'h04, 8'hCD);
    cyc(2);
    ticks = 0;
    repeat (3) begin
      sync_ext = 1'b0;
      cyc(4);
      sync_ext = 1'b1;
      cyc(4);
    end
    check({6'h00, sync_oe_n, 1'b0}, 8'h02);
    check(8'(ticks), 8'h03);
    i_host.wr(8'h04, 8'hFF);
  endtask

  // cuts a hang short after well over the planned run
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial begin
    nrst_i = 1'b0;
    dac = 8'h80;
    tach = 4'h0;
    cstart = 1'b0;
    full_ext = 1'b1;
    sync_ext = 1'b1;
    bad_count = 0;
    comparisons = 0;
    ticks = 0;
    cyc(4);
    nrst_i = 1'b1;
    cyc(1);
    t_reset();
    t_minmax();
    t_ovf();
    t_pins();
    t_sync();
    print_verdict();
  end
endmodule
